/* verilog/sram_controller.sv */
// SRAM controller end: queues user requests and issues one command per cycle.
`timescale 1ns/1ps
module sram_controller (
    input  wire logic                     mclk,
    input  wire logic                     rstn,
    sram_link.ctrl                        link,
    input  wire logic                     req_valid,
    input  wire sram_pkg::req_s           req_data,
    output logic                          req_ready,
    input  wire logic                     issue_pause,
    output logic                          rd_valid,
    output logic [sram_pkg::DATA_W-1:0]   rd_data,
    output logic [sram_pkg::ADDR_W-1:0]   rd_addr
);
    import sram_pkg::*;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } stage_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              adv_n;
        logic              rw_n;
        logic [BYTES-1:0]  be_n;
        logic              ce_n;
        logic              ce_hi;
        logic              ce_lo2;
        stage_s            cmd;
        stage_s            p1;
        stage_s            p2;
        logic [DATA_W-1:0] dq_out;
        logic              dq_oe;
        logic              rd_valid;
        logic [DATA_W-1:0] rd_data;
        logic [ADDR_W-1:0] rd_addr;
    } ctrl_s;

    ctrl_s            q;
    ctrl_s            d;
    logic             head_valid;
    logic [REQ_W-1:0] head_bits;
    req_s             head;
    logic             pop;

    assign pop  = head_valid & ~issue_pause;
    assign head = req_s'(head_bits);

    // Queue in front of the command pins; pausing the issue side back-pressures users.
    sync_fifo #(
        .WIDTH (REQ_W),
        .DEPTH (FIFO_DEPTH)
    ) u_queue (
        .mclk      (mclk),
        .rstn      (rstn),
        .in_valid  (req_valid),
        .in_data   (req_data),
        .in_ready  (req_ready),
        .out_valid (head_valid),
        .out_data  (head_bits),
        .out_ready (~issue_pause)
    );

    // Pins are set one edge before the device samples them; the tracking pipeline
    // lines up with the device's own, so data is driven and taken at fixed edges.
    always_comb
    begin
        d        = q;
        d.adv_n  = 1'b0; // Loads and deselects; a burst step is chosen below.
        d.ce_hi  = 1'b1;
        d.ce_lo2 = 1'b0;
        if (pop)
        begin
            // The next word of the same kind is a burst step, which spares an address load.
            d.adv_n = q.cmd.valid & (q.cmd.write == head.write) &
                      (head.addr == q.addr + 1'b1);
            d.addr  = head.addr;
            d.ce_n  = 1'b0;
            d.rw_n  = ~head.write;
            d.be_n  = !head.write ? BE_NONE_N : (head.whole ? BE_ALL_N : head.be_n);
            d.cmd   = '{valid: 1'b1, write: head.write, addr: head.addr, data: head.data};
        end
        else
        begin
            d.ce_n  = 1'b1;
            d.rw_n  = 1'b1;
            d.be_n  = BE_NONE_N;
            d.cmd   = '{valid: 1'b0, write: 1'b0, addr: q.addr, data: DATA_RST};
        end
        d.p1 = q.cmd;
        d.p2 = q.p1;

        // The driver drops at the same edge that the memory turns its own on.
        d.dq_oe  = q.p1.valid & q.p1.write;
        d.dq_out = q.p1.write ? q.p1.data : q.dq_out;

        d.rd_valid = q.p2.valid & ~q.p2.write;
        if (q.p2.valid && !q.p2.write)
        begin
            d.rd_data = link.bus_dq;
            d.rd_addr = q.p2.addr;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '{addr: ADDR_RST, adv_n: 1'b0, rw_n: 1'b1, be_n: BE_NONE_N, ce_n: 1'b1,
                   ce_hi: 1'b1, ce_lo2: 1'b0,
                   cmd: '{1'b0, 1'b0, ADDR_RST, DATA_RST},
                   p1: '{1'b0, 1'b0, ADDR_RST, DATA_RST},
                   p2: '{1'b0, 1'b0, ADDR_RST, DATA_RST},
                   dq_out: DATA_RST, dq_oe: 1'b0, rd_valid: 1'b0,
                   rd_data: DATA_RST, rd_addr: ADDR_RST};
        end
        else
        begin
            q <= d;
        end
    end

    assign link.addr                  = q.addr;
    assign link.advance_load_n        = q.adv_n;
    assign link.rw_n                  = q.rw_n;
    assign link.byte_write_en_n       = q.be_n;
    assign link.chip_enable_n         = q.ce_n;
    assign link.chip_enable_hi        = q.ce_hi;
    assign link.chip_enable_lo_second = q.ce_lo2;
    assign link.ctrl_dq_out           = q.dq_out;
    assign link.ctrl_dq_oe            = q.dq_oe;
    assign rd_valid                   = q.rd_valid;
    assign rd_data                    = q.rd_data;
    assign rd_addr                    = q.rd_addr;
endmodule

/* verilog/sram_pkg.sv */
// Constants and types shared by both ends of the synchronous SRAM command link.
// What this block does
// - Strobe low, chips enabled: new read/write.
// - Strobe low, any enable off: deselect.
// - Strobe high: burst continuation, optional for controller.
// - A write updates only enabled bytes.
// - Full-width write asserts all four byte enables.
// - A command is taken every cycle.
// - Read-write-read: 5 pipelined, 4 flow-through cycles.
// - Controller releases bus at the same edge the memory starts driving.
package sram_pkg;
    localparam int                 DATA_W          = 32;
    localparam int                 BYTES           = 4;
    localparam int                 BYTE_W          = 8;
    localparam int                 ADDR_W          = 8;
    localparam int                 DEPTH           = 256;
    localparam int                 FIFO_DEPTH      = 16;
    // Cycles from the first command of a read, write, read to the last read data.
    localparam int                 RWR_CYCLES_PIPE = 5;
    localparam int                 RWR_CYCLES_FLOW = 4;
    // Byte write enables are active low.
    localparam logic [BYTES-1:0]   BE_ALL_N        = 4'h0;
    localparam logic [BYTES-1:0]   BE_NONE_N       = 4'hF;
    localparam logic [ADDR_W-1:0]  ADDR_RST        = 8'h00;
    localparam logic [DATA_W-1:0]  DATA_RST        = 32'h0000_0000;

    // Command type held for burst continuation.
    typedef enum logic [1:0] {KIND_IDLE, KIND_READ, KIND_WRITE} kind_e;

    // One user request as it sits in the controller's queue.
    typedef struct packed {
        logic              write;
        logic              whole;
        logic [ADDR_W-1:0] addr;
        logic [BYTES-1:0]  be_n;
        logic [DATA_W-1:0] data;
    } req_s;

    localparam int                 REQ_W           = $bits(req_s);
endpackage

/* verilog/sram_link.sv */
// Interface joining the SRAM controller end and the SRAM device end.
`timescale 1ns/1ps
interface sram_link;
    import sram_pkg::*;
    logic [ADDR_W-1:0] addr;
    logic              advance_load_n;
    logic              rw_n;
    logic [BYTES-1:0]  byte_write_en_n;
    logic              chip_enable_n;
    logic              chip_enable_hi;
    logic              chip_enable_lo_second;
    logic [DATA_W-1:0] ctrl_dq_out;
    logic              ctrl_dq_oe;
    logic [DATA_W-1:0] mem_dq_out;
    logic              mem_dq_oe;
    logic [DATA_W-1:0] bus_dq;

    // Resolved data bus; the memory wins if both ever drive, an undriven bus reads zero.
    assign bus_dq = mem_dq_oe ? mem_dq_out : (ctrl_dq_oe ? ctrl_dq_out : DATA_RST);

    modport mem (
        input  addr, advance_load_n, rw_n, byte_write_en_n,
        input  chip_enable_n, chip_enable_hi, chip_enable_lo_second, bus_dq,
        output mem_dq_out, mem_dq_oe
    );
    modport ctrl (
        output addr, advance_load_n, rw_n, byte_write_en_n,
        output chip_enable_n, chip_enable_hi, chip_enable_lo_second,
        output ctrl_dq_out, ctrl_dq_oe,
        input  bus_dq
    );
endinterface

/* verilog/sync_fifo.sv */
// Synchronous FIFO with valid and ready on both sides; depth must be a power of two.
`timescale 1ns/1ps
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             rstn,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int          PW       = $clog2(DEPTH);
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

    typedef struct packed {
        logic [PW-1:0] wr;
        logic [PW-1:0] rd;
        logic [PW:0]   cnt;
        logic          room;
        logic          avail;
    } fifo_s;

    fifo_s            q;
    fifo_s            d;
    logic [WIDTH-1:0] store [DEPTH];
    logic             push;
    logic             pop;

    // Flags are registered so that ready and valid come straight from flops.
    always_comb
    begin
        d    = q;
        push = in_valid & q.room;
        pop  = out_ready & q.avail;
        if (push)
        begin
            d.wr = q.wr + 1'b1;
        end
        if (pop)
        begin
            d.rd = q.rd + 1'b1;
        end
        unique case ({push, pop})
            2'b10:   d.cnt = q.cnt + 1'b1;
            2'b01:   d.cnt = q.cnt - 1'b1;
            default: d.cnt = q.cnt;
        endcase
        // Stored in the sense of ready and valid, so no gate follows the flops.
        d.room  = (d.cnt != FULL_CNT);
        d.avail = (d.cnt != '0);
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '{wr: '0, rd: '0, cnt: '0, room: 1'b1, avail: 1'b0};
        end
        else
        begin
            q <= d;
        end
    end

    // Storage has no reset; an entry is only read after it was written.
    always_ff @(posedge mclk)
    begin
        if (push)
        begin
            store[q.wr] <= in_data;
        end
    end

    assign in_ready  = q.room;
    assign out_valid = q.avail;
    assign out_data  = store[q.rd];
endmodule

/* verilog/sram_device.sv */
// SRAM device end: command decode, burst counter, late-write pipeline and byte-lane array.
`timescale 1ns/1ps
module sram_device (
    input  wire logic                     mclk,
    input  wire logic                     rstn,
    sram_link.mem                         link,
    output logic                          write_done,
    output logic [sram_pkg::ADDR_W-1:0]   write_addr,
    output sram_pkg::kind_e               loaded_kind
);
    import sram_pkg::*;

    typedef struct packed {
        logic              s1_valid;
        logic              s1_write;
        logic [ADDR_W-1:0] s1_addr;
        logic [BYTES-1:0]  s1_be_n;
        logic              s2_valid;
        logic              s2_write;
        logic [ADDR_W-1:0] s2_addr;
        logic [BYTES-1:0]  s2_be_n;
        kind_e             last_kind;
        logic [ADDR_W-1:0] burst_addr;
        logic [DATA_W-1:0] dout;
        logic              dout_oe;
        logic              wrote;
        logic [ADDR_W-1:0] wrote_addr;
    } dev_s;

    dev_s              q;
    dev_s              d;
    kind_e             kind;
    logic [ADDR_W-1:0] caddr;
    logic              selected;
    logic              lane_we;
    logic              fwd_hit;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] fwd_word;

    // All three enables must be active for a command to select the part.
    assign selected = ~link.chip_enable_n & link.chip_enable_hi & ~link.chip_enable_lo_second;
    assign lane_we  = q.s2_valid & q.s2_write;
    // A read directly behind a write to the same word sees the bytes landing now.
    assign fwd_hit  = lane_we & (q.s2_addr == q.s1_addr);

    // One array per byte lane, so a partial write never touches other bytes.
    for (genvar b = 0; b < BYTES; b++)
    begin : g_lane
        logic [BYTE_W-1:0] lane_mem [DEPTH];

        always_ff @(posedge mclk)
        begin
            if (lane_we && !q.s2_be_n[b])
            begin
                lane_mem[q.s2_addr] <= link.bus_dq[b*BYTE_W +: BYTE_W];
            end
        end

        assign rd_word[b*BYTE_W +: BYTE_W]  = lane_mem[q.s1_addr];
        assign fwd_word[b*BYTE_W +: BYTE_W] = (fwd_hit && !q.s2_be_n[b]) ?
                                              link.bus_dq[b*BYTE_W +: BYTE_W] :
                                              rd_word[b*BYTE_W +: BYTE_W];
    end

    // Decode the sampled command, then step the two-stage pipeline.
    // Nothing here ever stalls, so a new command is taken on every edge.
    always_comb
    begin
        d     = q;
        kind  = KIND_IDLE;
        caddr = q.burst_addr;
        if (!link.advance_load_n)
        begin
            if (selected)
            begin
                kind = link.rw_n ? KIND_READ : KIND_WRITE;
            end
            else
            begin
                kind = KIND_IDLE;
            end
            caddr       = link.addr;
            d.last_kind = kind;
        end
        else
        begin
            // Burst after a deselect stays deselected; the counter wraps at the top.
            kind  = q.last_kind;
            caddr = q.burst_addr + 1'b1;
        end
        d.burst_addr = caddr;

        d.s1_valid = (kind != KIND_IDLE);
        d.s1_write = (kind == KIND_WRITE);
        d.s1_addr  = caddr;
        d.s1_be_n  = link.byte_write_en_n;

        d.s2_valid = q.s1_valid;
        d.s2_write = q.s1_write;
        d.s2_addr  = q.s1_addr;
        d.s2_be_n  = q.s1_be_n;

        // Read data goes out one edge after the command, to be sampled at the second.
        d.dout_oe = q.s1_valid & ~q.s1_write;
        if (q.s1_valid && !q.s1_write)
        begin
            d.dout = fwd_word;
        end

        // Write data is taken off the bus two edges after its command.
        d.wrote      = lane_we;
        d.wrote_addr = lane_we ? q.s2_addr : q.wrote_addr;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '{s1_valid: 1'b0, s1_write: 1'b0, s1_addr: ADDR_RST, s1_be_n: BE_NONE_N,
                   s2_valid: 1'b0, s2_write: 1'b0, s2_addr: ADDR_RST, s2_be_n: BE_NONE_N,
                   last_kind: KIND_IDLE, burst_addr: ADDR_RST, dout: DATA_RST,
                   dout_oe: 1'b0, wrote: 1'b0, wrote_addr: ADDR_RST};
        end
        else
        begin
            q <= d;
        end
    end

    assign link.mem_dq_out = q.dout;
    assign link.mem_dq_oe  = q.dout_oe;
    assign write_done      = q.wrote;
    assign write_addr      = q.wrote_addr;
    assign loaded_kind     = q.last_kind;
endmodule

/* verification/sram_link_props.sv */
// Checker for command decode and data-bus timing across the SRAM link.
`timescale 1ns/1ps
module sram_link_props (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic advance_load_n,
    input  wire logic rw_n,
    input  wire logic chip_enable_n,
    input  wire logic chip_enable_hi,
    input  wire logic chip_enable_lo_second,
    input  wire logic ctrl_dq_oe,
    input  wire logic mem_dq_oe
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // Command decode; a load needs all three enables active, else it is a deselect.
    logic sel;
    logic ld_rd;
    logic ld_wr;
    logic desel;
    assign sel   = !chip_enable_n && chip_enable_hi && !chip_enable_lo_second;
    assign ld_rd = !advance_load_n && sel && rw_n;
    assign ld_wr = !advance_load_n && sel && !rw_n;
    assign desel = !advance_load_n && !sel;

    // Kind of the last load, which a burst continuation repeats.
    logic [1:0] last_q;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            last_q <= 2'h0;
        end
        else if (!advance_load_n)
        begin
            last_q <= {ld_wr, ld_rd};
        end
    end

    // Bus ownership two edges after each command, and never both ends driving at once.
    a_read_drives: assert property (ld_rd |-> ##2 mem_dq_oe)
        else $error("read did not drive the bus");
    a_write_quiet: assert property (ld_wr |-> ##2 !mem_dq_oe)
        else $error("memory drove during a write");
    a_write_data: assert property (ld_wr |-> ##2 ctrl_dq_oe)
        else $error("controller did not drive write data");
    a_deselect_quiet: assert property (desel |-> ##2 !mem_dq_oe)
        else $error("memory drove after a deselect");
    a_no_contention: assert property (!(ctrl_dq_oe && mem_dq_oe))
        else $error("both ends drive the bus");
    a_reads_stream: assert property (ld_rd ##1 ld_rd |-> ##1 mem_dq_oe [*2])
        else $error("back-to-back reads left a gap");
    a_rwr_five: assert property (ld_rd ##1 ld_wr ##1 ld_rd |->
        ##1 ctrl_dq_oe ##1 mem_dq_oe)
        else $error("read-write-read took too long");
    a_write_release: assert property (ld_wr ##1 ld_rd |->
        ##1 ctrl_dq_oe ##1 (!ctrl_dq_oe && mem_dq_oe))
        else $error("bus not handed over after write");
    // A burst step repeats the kind of the last load.
    a_burst_read: assert property (advance_load_n && last_q[0] |-> ##2 mem_dq_oe)
        else $error("burst read did not drive the bus");
    a_burst_write: assert property (advance_load_n && last_q[1] |-> ##2 ctrl_dq_oe)
        else $error("burst write data not on the bus");

    // Main traffic shapes.
    c_rwr: cover property (ld_rd ##1 ld_wr ##1 ld_rd);
    c_wr_rd: cover property (ld_wr ##1 ld_rd);
    c_desel_rd: cover property (desel ##1 ld_rd);
    c_burst_rd: cover property (advance_load_n && last_q[0]);
endmodule

/* verification/tb_top.sv */
// Bench joining both link ends, with a request driver and an in-order read model.
`timescale 1ns/1ps
module tb_top;
    import sram_pkg::*;
    logic              mclk;
    logic              rstn;
    logic              req_valid;
    req_s              req_data;
    logic              req_ready;
    logic              issue_pause;
    logic              rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic [ADDR_W-1:0] rd_addr;
    logic              write_done;
    logic [ADDR_W-1:0] write_addr;
    kind_e             loaded_kind;
    logic [DATA_W-1:0] mem_m [DEPTH];
    logic [DATA_W-1:0] exp_d [$];
    logic [ADDR_W-1:0] exp_a [$];
    logic [ADDR_W-1:0] exp_w [$];
    int                error_cnt;
    int                checks;
    int                wr_cnt;
    int                wr_seen;

    sram_link link ();
    sram_device sram_device_inst (.mclk(mclk), .rstn(rstn), .link(link.mem),
        .write_done(write_done), .write_addr(write_addr), .loaded_kind(loaded_kind));
    sram_controller sram_controller_inst (.mclk(mclk), .rstn(rstn), .link(link.ctrl),
        .req_valid(req_valid), .req_data(req_data), .req_ready(req_ready),
        .issue_pause(issue_pause), .rd_valid(rd_valid), .rd_data(rd_data), .rd_addr(rd_addr));
    sram_link_props sram_link_props_inst (.mclk(mclk), .rstn(rstn),
        .advance_load_n(link.advance_load_n), .rw_n(link.rw_n),
        .chip_enable_n(link.chip_enable_n), .chip_enable_hi(link.chip_enable_hi),
        .chip_enable_lo_second(link.chip_enable_lo_second),
        .ctrl_dq_oe(link.ctrl_dq_oe), .mem_dq_oe(link.mem_dq_oe));

    // Free-running 100 ns clock.
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Offer one request until taken; valid stays up so pushes run back to back.
    task automatic push(input logic wr, input logic whole, input logic [ADDR_W-1:0] a,
                        input logic [BYTES-1:0] be_n, input logic [DATA_W-1:0] d);
        logic taken = 1'b0;
        req_valid <= 1'b1;
        req_data  <= '{wr, whole, a, be_n, d};
        while (!taken)
        begin
            @(negedge mclk);
            taken = (req_ready === 1'b1);
            @(posedge mclk);
        end
        if (wr)
        begin
            wr_cnt++;
            exp_w.push_back(a);
            for (int b = 0; b < BYTES; b++)
                if (whole || !be_n[b])
                    mem_m[a][BYTE_W*b +: BYTE_W] = d[BYTE_W*b +: BYTE_W];
        end
        else
        begin
            exp_d.push_back(mem_m[a]);
            exp_a.push_back(a);
        end
    endtask

    // Score returned reads in order; count landed writes.
    always @(negedge mclk)
    begin
        if (rd_valid === 1'b1)
        begin
            check("read data", rd_data, exp_d.pop_front());
            check("read address", DATA_W'(rd_addr), DATA_W'(exp_a.pop_front()));
        end
        if (write_done === 1'b1)
        begin
            wr_seen++;
            check("write address", DATA_W'(write_addr), DATA_W'(exp_w.pop_front()));
        end
    end

    // Under two hundred cycles of traffic are expected; a hang ends at 3000 cycles, far beyond that.
    initial
    begin
        #(3000 * 100);
        error_cnt++;
        conclude();
    end

    initial
    begin
        rstn = 1'b0;
        req_valid = 1'b0;
        req_data = '0;
        issue_pause = 1'b0;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        @(negedge mclk);
        check("reset drive", DATA_W'({link.ctrl_dq_oe, link.mem_dq_oe}), 32'h0);
        check("reset select", DATA_W'(link.chip_enable_n), 32'h1);
        @(posedge mclk);
        // Full-width writes, then the same words read every cycle.
        for (int i = 0; i < 4; i++)
            push(1'b1, 1'b1, ADDR_W'(i), BE_NONE_N, 32'hA5C3_0000 + i);
        for (int i = 0; i < 4; i++)
            push(1'b0, 1'b0, ADDR_W'(i), BE_NONE_N, DATA_RST);
        // Every byte-enable pattern, read straight behind the partial write.
        for (int i = 0; i < 16; i++)
        begin
            push(1'b1, 1'b1, ADDR_W'(8'h40 + i), BE_ALL_N, 32'h1111_1111 * i);
            push(1'b1, 1'b0, ADDR_W'(8'h40 + i), 4'(i), 32'hFEDC_BA98);
            push(1'b0, 1'b0, ADDR_W'(8'h40 + i), BE_NONE_N, DATA_RST);
        end
        push(1'b0, 1'b0, 8'h00, BE_NONE_N, DATA_RST);
        push(1'b1, 1'b1, 8'h01, BE_ALL_N, 32'h5A5A_0001);
        push(1'b0, 1'b0, 8'h01, BE_NONE_N, DATA_RST);
        // Let the queue empty first, or the last read stays queued and the last fill push is never taken.
        req_valid <= 1'b0;
        repeat (2) @(posedge mclk);
        // Stall issue so the queue fills to its limit, then drain by reading back.
        issue_pause <= 1'b1;
        for (int i = 0; i < FIFO_DEPTH; i++)
            push(1'b1, 1'b1, ADDR_W'(8'h80 + i), BE_ALL_N, 32'h0BAD_0000 + i);
        req_valid <= 1'b0;
        @(negedge mclk);
        check("queue full", DATA_W'(req_ready), 32'h0);
        @(posedge mclk);
        issue_pause <= 1'b0;
        for (int i = 0; i < FIFO_DEPTH; i++)
            push(1'b0, 1'b0, ADDR_W'(8'h80 + i), BE_NONE_N, DATA_RST);
        req_valid <= 1'b0;
        for (int n = 0; n < 200 && exp_d.size() != 0; n++)
            @(posedge mclk);
        repeat (8) @(posedge mclk);
        check("reads left", DATA_W'(exp_d.size()), 32'h0);
        check("writes landed", DATA_W'(wr_seen), DATA_W'(wr_cnt));
        check("idle kind", DATA_W'(loaded_kind), DATA_W'(KIND_IDLE));
        conclude();
    end
endmodule
